// ===== core/sdc_regs.svh
// Purpose: constants shared by both ends of the sdram link
// Assumes: x16 data width variant, one 100 MHz clock
// Notes: timing counts are whole cycles of that clock
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH
`define SDC_BANKS 4
`define SDC_BA_W 2
`define SDC_ROWS 8192
`define SDC_ROW_W 13
`define SDC_COL_W 9
`define SDC_ADDR_W 13
`define SDC_DQ_W 16
`define SDC_DQM_W 2
`define SDC_PRE_BIT 10
`define SDC_BURST_LSB 0
`define SDC_BT_BIT 3
`define SDC_BURST_1 3'h0
`define SDC_BURST_2 3'h1
`define SDC_BURST_4 3'h2
`define SDC_BURST_8 3'h3
`define SDC_BURST_PAGE 3'h7
`define SDC_PAGE_LEN 10'h200
`define SDC_CAS_LAT 2
`define SDC_TRCD 4'h2
`define SDC_TRP 4'h2
`define SDC_TRFC 4'h7
`define SDC_REF_MS 16
`define SDC_CLK_KHZ 100000
`define SDC_REF_CYC ((`SDC_REF_MS * `SDC_CLK_KHZ) / `SDC_ROWS)
`endif

// ===== core/sdc_pkg.sv
// Purpose: types shared by both ends of the sdram link
// Assumes: command code is {ras_n, cas_n, we_n} with cs_n low
// Notes: controller states are one-hot
package sdc_pkg;
  typedef enum logic [2:0] {
    SDC_LMR = 3'h0, SDC_REF = 3'h1, SDC_PRE = 3'h2, SDC_ACT = 3'h3,
    SDC_WR = 3'h4, SDC_RD = 3'h5, SDC_BST = 3'h6, SDC_NOP = 3'h7
  } sdc_cmd_type;
  typedef enum logic [5:0] {
    SDC_S_INIT = 6'h01, SDC_S_IDLE = 6'h02, SDC_S_RCD = 6'h04,
    SDC_S_BURST = 6'h08, SDC_S_WAIT = 6'h10, SDC_S_REFR = 6'h20
  } sdc_state_type;
endpackage : sdc_pkg

// ===== core/sdc_if.sv
// Purpose: pin bundle between sdram controller and sdram device
// Assumes: both ends run on the same clock
// Notes: dq is resolved here from the two output enables
`timescale 1ns/1ps
`include "sdc_regs.svh"
interface sdc_if (input wire logic clock);
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [`SDC_BA_W-1:0] ba;
  logic [`SDC_ADDR_W-1:0] addr;
  logic [`SDC_DQM_W-1:0] dqm;
  logic [`SDC_DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe_n;
  logic [`SDC_DQ_W-1:0] mem_dq_o;
  logic mem_dq_oe_n;
  logic [`SDC_DQ_W-1:0] dq;
  // bus level: whoever enables drives, the controller wins if both enable, an idle bus reads as zero
  assign dq = !ctl_dq_oe_n ? ctl_dq_o : (!mem_dq_oe_n ? mem_dq_o : '0);
  modport ctrl (input clock, output cke, output cs_n, output ras_n,
    output cas_n, output we_n, output ba, output addr, output dqm,
    output ctl_dq_o, output ctl_dq_oe_n, input dq);
  modport mem (input clock, input cke, input cs_n, input ras_n,
    input cas_n, input we_n, input ba, input addr, input dqm,
    output mem_dq_o, output mem_dq_oe_n, input dq);
endinterface : sdc_if

// ===== core/sdc_fifo.sv
// Purpose: write data buffer between user and controller
// Assumes: depth is a power of two
// Notes: full and empty are registered flags
`timescale 1ns/1ps
module sdc_fifo import sdc_pkg::*; #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int AW = $clog2(D)
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [AW:0] count
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } sdc_fifo_type;
  localparam sdc_fifo_type RST = '{mem: '0, wp: '0, rp: '0, cnt: '0,
    full: 1'b0, empty: 1'b1};
  sdc_fifo_type st;
  sdc_fifo_type next_st;
  logic push;
  logic pop;

  // pointer and flag update
  always_comb begin
    next_st = st;
    push = in_valid && !st.full;
    pop = out_ready && !st.empty;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_st.full = next_st.cnt == (AW+1)'(D);
    next_st.empty = next_st.cnt == '0;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= RST;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = !st.full;
  assign out_valid = !st.empty;
  assign out_data = st.mem[st.rp];
  assign count = st.cnt;
endmodule : sdc_fifo

// ===== core/sdc_ctrl.sv
// Purpose: controller end: turns user requests into sdram commands
// Assumes: fixed burst length, sequential order, one request at a time
// Notes: write words wait in an 8 word fifo; reads return as pulses
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_ctrl import sdc_pkg::*; #(
  parameter logic [2:0] BURST_CODE = `SDC_BURST_4,
  parameter int FIFO_D = 8
) (
  input wire logic clock,
  input wire logic arst_n,
  sdc_if.ctrl bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [`SDC_BA_W-1:0] req_bank,
  input wire logic [`SDC_ROW_W-1:0] req_row,
  input wire logic [`SDC_COL_W-1:0] req_col,
  input wire logic req_autopre,
  input wire logic wd_valid,
  output logic wd_ready,
  input wire logic [`SDC_DQ_W-1:0] wd_data,
  output logic rd_valid,
  output logic [`SDC_DQ_W-1:0] rd_data
);
  localparam logic [9:0] LEN = 10'h1 << BURST_CODE;
  localparam logic [9:0] RD_N = LEN + 10'(`SDC_CAS_LAT - 1);
  localparam logic [7:0] REF_N = 8'(`SDC_REF_CYC - 1);
  typedef struct packed {
    sdc_state_type state;
    logic cke;
    logic [9:0] cnt;
    logic [7:0] ref_tmr;
    logic ref_due;
    logic wr;
    logic ap;
    logic [`SDC_BA_W-1:0] bk;
    logic [`SDC_ROW_W-1:0] row;
    logic [`SDC_COL_W-1:0] col;
    logic [3:0] cmd;
    logic [`SDC_BA_W-1:0] ba;
    logic [`SDC_ADDR_W-1:0] addr;
    logic [`SDC_DQ_W-1:0] dq_o;
    logic dq_oe_n;
    logic req_ready;
    logic rd_valid;
    logic [`SDC_DQ_W-1:0] rd_data;
  } sdc_ctrl_type;
  localparam sdc_ctrl_type RST = '{state: SDC_S_INIT, cke: 1'b0, cnt: '0,
    ref_tmr: REF_N, ref_due: 1'b0, wr: 1'b0, ap: 1'b0, bk: '0, row: '0,
    col: '0, cmd: {1'b1, SDC_NOP}, ba: '0, addr: '0, dq_o: '0,
    dq_oe_n: 1'b1, req_ready: 1'b0, rd_valid: 1'b0, rd_data: '0};
  sdc_ctrl_type st;
  sdc_ctrl_type next_st;
  logic pop;
  logic [`SDC_DQ_W-1:0] fifo_data;
  logic [$clog2(FIFO_D):0] fifo_cnt;

  sdc_fifo #(.W(`SDC_DQ_W), .D(FIFO_D)) u_wfifo (
    .clock(clock), .arst_n(arst_n), .in_valid(wd_valid),
    .in_ready(wd_ready), .in_data(wd_data), .out_valid(),
    .out_ready(pop), .out_data(fifo_data), .count(fifo_cnt));

  // command sequencer
  always_comb begin
    next_st = st;
    pop = 1'b0;
    next_st.cmd = {1'b1, SDC_NOP};
    next_st.rd_valid = 1'b0;
    next_st.req_ready = 1'b0;
    next_st.cke = 1'b1; // clock enable rises on the first edge out of reset
    // refresh timer: one row every 16 ms / 8192
    if (st.ref_tmr == '0) begin
      next_st.ref_tmr = REF_N;
    end else begin
      next_st.ref_tmr = st.ref_tmr - 8'h1;
    end
    if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 10'h1;
    end
    unique case (st.state)
      SDC_S_INIT: begin
        next_st.cmd = {1'b0, SDC_LMR};
        next_st.addr = `SDC_ADDR_W'(BURST_CODE);
        next_st.cnt = 10'(`SDC_TRP);
        next_st.state = SDC_S_WAIT;
      end
      SDC_S_IDLE: begin
        if (st.ref_due) begin
          // auto refresh only, never self refresh
          next_st.cmd = {1'b0, SDC_REF};
          next_st.ref_due = 1'b0;
          next_st.cnt = 10'(`SDC_TRFC);
          next_st.state = SDC_S_REFR;
        end else if (req_valid && st.req_ready) begin
          // open the row first, column command follows
          next_st.cmd = {1'b0, SDC_ACT};
          next_st.ba = req_bank;
          next_st.addr = req_row;
          next_st.bk = req_bank;
          next_st.col = req_col;
          next_st.wr = req_write;
          next_st.ap = req_autopre;
          next_st.cnt = 10'(`SDC_TRCD - 4'h1);
          next_st.state = SDC_S_RCD;
        end else begin
          // no ready while a refresh tick lands, so a handshake is never lost
          next_st.req_ready = st.ref_tmr != '0;
        end
      end
      SDC_S_RCD: begin
        if (st.cnt == '0 && (!st.wr || 10'(fifo_cnt) >= LEN)) begin
          // start column plus auto precharge flag
          next_st.cmd = {1'b0, st.wr ? SDC_WR : SDC_RD};
          next_st.ba = st.bk;
          next_st.addr = `SDC_ADDR_W'(st.col);
          next_st.addr[`SDC_PRE_BIT] = st.ap;
          next_st.cnt = st.wr ? LEN - 10'h1 : RD_N;
          next_st.state = SDC_S_BURST;
          if (st.wr) begin
            pop = 1'b1;
            next_st.dq_o = fifo_data;
            next_st.dq_oe_n = 1'b0;
          end
        end
      end
      SDC_S_BURST: begin
        if (st.wr && st.cnt != '0) begin
          pop = 1'b1;
          next_st.dq_o = fifo_data;
        end
        if (!st.wr && st.cnt < LEN) begin
          next_st.rd_valid = 1'b1;
          next_st.rd_data = bus.dq;
        end
        if (st.cnt == '0) begin
          next_st.dq_oe_n = 1'b1;
          next_st.cnt = 10'(`SDC_TRP) + 10'h1;
          next_st.state = SDC_S_WAIT;
          if (!st.ap) begin
            next_st.cmd = {1'b0, SDC_PRE};
            next_st.ba = st.bk;
            next_st.addr = '0;
          end
        end
      end
      SDC_S_WAIT, SDC_S_REFR: begin
        if (st.cnt == '0) begin
          next_st.state = SDC_S_IDLE;
        end
      end
      default: begin
        next_st.state = SDC_S_IDLE;
      end
    endcase
    // a timer tick in the clearing cycle is kept
    if (st.ref_tmr == '0) begin
      next_st.ref_due = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= RST;
    end else begin
      st <= next_st;
    end
  end

  assign bus.cke = st.cke;
  assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = st.cmd;
  assign bus.ba = st.ba;
  assign bus.addr = st.addr;
  assign bus.dqm = '0;
  assign bus.ctl_dq_o = st.dq_o;
  assign bus.ctl_dq_oe_n = st.dq_oe_n;
  assign req_ready = st.req_ready;
  assign rd_valid = st.rd_valid;
  assign rd_data = st.rd_data;
endmodule : sdc_ctrl

// ===== core/sdc_mem.sv
// Purpose: device end: four-bank sdram command decoder and burst engine
// Assumes: x16 organisation, read latency of two clocks
// Notes: only a small slice of the array is stored, by low address bits
`timescale 1ns/1ps
`include "sdc_regs.svh"
// Overview of operation
// - all inputs taken on rising clock edge
// - four banks, 8192 rows, x16 has 512 columns
// - controller activates a row before column commands
// - active: bank lines pick bank, address picks row
// - column command address gives burst start column
// - burst lengths 1,2,4,8, page; terminate stops
// - burst columns generated internally in programmed order
// - auto precharge starts itself after burst end
// - new column accepted every clock cycle
// - one bank precharges while another is accessed
// - auto refresh and power-down modes provided
// - hot grade: refresh within 16 ms, no self refresh
// - precharge flag line picks auto precharge; low bits column
module sdc_mem import sdc_pkg::*; #(
  parameter int ROW_KEEP = 1,
  parameter int COL_KEEP = 3
) (
  input wire logic clock,
  input wire logic arst_n,
  sdc_if.mem bus,
  output logic [`SDC_BANKS-1:0] open_banks,
  output logic refresh_done,
  output logic access_error,
  output logic powered_down
);
  localparam int IW = `SDC_BA_W + ROW_KEEP + COL_KEEP;
  localparam int DEPTH = 1 << IW;
  typedef struct packed {
    logic [DEPTH-1:0][`SDC_DQ_W-1:0] mem;
    logic [`SDC_BANKS-1:0] open;
    logic [`SDC_BANKS-1:0][`SDC_ROW_W-1:0] row;
    logic [`SDC_BANKS-1:0][3:0] pre_cnt;
    logic [2:0] bcode;
    logic bt;
    logic busy;
    logic wr;
    logic ap;
    logic [`SDC_BA_W-1:0] bk;
    logic [`SDC_COL_W-1:0] start;
    logic [9:0] idx;
    logic rp_v;
    logic rp_m;
    logic [`SDC_DQ_W-1:0] rp_d;
    logic [`SDC_DQ_W-1:0] dq_o;
    logic dq_oe_n;
    logic refresh_done;
    logic access_error;
    logic powered_down;
  } sdc_mem_type;
  localparam sdc_mem_type RST = '{mem: '0, open: '0, row: '0,
    pre_cnt: '0, bcode: `SDC_BURST_1, bt: 1'b0, busy: 1'b0, wr: 1'b0,
    ap: 1'b0, bk: '0, start: '0, idx: '0, rp_v: 1'b0, rp_m: 1'b0,
    rp_d: '0, dq_o: '0, dq_oe_n: 1'b1, refresh_done: 1'b0,
    access_error: 1'b0, powered_down: 1'b0};
  sdc_mem_type st;
  sdc_mem_type next_st;
  sdc_cmd_type cmd;
  logic acc;
  logic acc_wr;
  logic [`SDC_BA_W-1:0] acc_bk;
  logic [`SDC_COL_W-1:0] acc_col;
  logic [IW-1:0] ix;
  logic [`SDC_COL_W-1:0] new_col;

  // number of locations for a burst length code
  function automatic logic [9:0] blen(input logic [2:0] code);
    unique case (code)
      `SDC_BURST_2: blen = 10'h2;
      `SDC_BURST_4: blen = 10'h4;
      `SDC_BURST_8: blen = 10'h8;
      `SDC_BURST_PAGE: blen = `SDC_PAGE_LEN;
      default: blen = 10'h1;
    endcase
  endfunction : blen

  // column of step i: wraps inside the burst block
  function automatic logic [`SDC_COL_W-1:0] col_at(
    input logic [`SDC_COL_W-1:0] s, input logic [9:0] i,
    input logic [2:0] code, input logic bt);
    logic [`SDC_COL_W-1:0] mask;
    logic [`SDC_COL_W-1:0] off;
    mask = `SDC_COL_W'(blen(code) - 10'h1);
    off = bt ? (s ^ i[`SDC_COL_W-1:0]) : (s + i[`SDC_COL_W-1:0]);
    col_at = (s & ~mask) | (off & mask);
  endfunction : col_at

  // command decode, burst engine and array access
  always_comb begin
    next_st = st;
    cmd = sdc_cmd_type'({bus.ras_n, bus.cas_n, bus.we_n});
    acc = 1'b0;
    acc_wr = 1'b0;
    acc_bk = st.bk;
    acc_col = '0;
    ix = '0;
    new_col = bus.addr[`SDC_COL_W-1:0]; // low lines carry column
    next_st.refresh_done = 1'b0;
    next_st.access_error = 1'b0;
    next_st.powered_down = !bus.cke; // low cke freezes the core
    if (bus.cke) begin
      // self-timed precharge countdown per bank
      for (int b = 0; b < `SDC_BANKS; b++) begin
        if (st.pre_cnt[b] != '0) begin
          next_st.pre_cnt[b] = st.pre_cnt[b] - 4'h1;
        end
      end
      // running burst: next column from internal counter
      if (st.busy) begin
        acc = 1'b1;
        acc_wr = st.wr;
        acc_bk = st.bk;
        acc_col = col_at(st.start, st.idx, st.bcode, st.bt);
        next_st.idx = st.idx + 10'h1;
        if (st.bcode != `SDC_BURST_PAGE &&
            st.idx + 10'h1 == blen(st.bcode)) begin
          next_st.busy = 1'b0;
          if (st.ap) begin
            next_st.open[st.bk] = 1'b0; // auto precharge at end
            next_st.pre_cnt[st.bk] = `SDC_TRP;
          end
        end
      end
      if (!bus.cs_n) begin
        unique case (cmd)
          SDC_ACT: begin
            if (st.open[bus.ba] || st.pre_cnt[bus.ba] != '0) begin
              next_st.access_error = 1'b1;
            end else begin
              next_st.open[bus.ba] = 1'b1; // bank and row open
              next_st.row[bus.ba] = bus.addr;
            end
          end
          SDC_RD, SDC_WR: begin
            if (!st.open[bus.ba]) begin
              next_st.access_error = 1'b1;
            end else begin
              // new column each cycle replaces any burst
              acc = 1'b1;
              acc_wr = cmd == SDC_WR;
              acc_bk = bus.ba;
              acc_col = new_col;
              next_st.start = new_col;
              next_st.idx = 10'h1;
              next_st.wr = acc_wr;
              next_st.bk = bus.ba;
              next_st.ap = bus.addr[`SDC_PRE_BIT];
              next_st.busy = blen(st.bcode) != 10'h1;
              if (blen(st.bcode) == 10'h1 && bus.addr[`SDC_PRE_BIT]) begin
                next_st.open[bus.ba] = 1'b0;
                next_st.pre_cnt[bus.ba] = `SDC_TRP;
              end
            end
          end
          SDC_PRE: begin
            // other banks keep bursting meanwhile
            for (int b = 0; b < `SDC_BANKS; b++) begin
              if (bus.addr[`SDC_PRE_BIT] || bus.ba == `SDC_BA_W'(b)) begin
                next_st.open[b] = 1'b0;
                next_st.pre_cnt[b] = `SDC_TRP;
                if (st.bk == `SDC_BA_W'(b)) begin
                  next_st.busy = 1'b0;
                end
              end
            end
          end
          SDC_REF: begin
            if (st.open != '0 || st.busy) begin
              next_st.access_error = 1'b1;
            end else begin
              next_st.refresh_done = 1'b1; // auto refresh
            end
          end
          SDC_LMR: begin
            if (st.open != '0 || st.busy) begin
              next_st.access_error = 1'b1;
            end else begin
              next_st.bcode = bus.addr[`SDC_BURST_LSB +: 3];
              next_st.bt = bus.addr[`SDC_BT_BIT];
            end
          end
          SDC_BST: begin
            next_st.busy = 1'b0; // burst terminate
          end
          SDC_NOP: begin
          end
        endcase
      end
      // array slice index: bank, low row bits, low column bits
      ix = {acc_bk, st.row[acc_bk][ROW_KEEP-1:0], acc_col[COL_KEEP-1:0]};
      // write data and mask taken at this edge
      if (acc && acc_wr) begin
        for (int l = 0; l < `SDC_DQM_W; l++) begin
          if (!bus.dqm[l]) begin
            next_st.mem[ix][l*8 +: 8] = bus.dq[l*8 +: 8];
          end
        end
      end
      // read pipeline: one stage then output flop
      next_st.rp_v = acc && !acc_wr;
      next_st.rp_m = &bus.dqm;
      next_st.rp_d = st.mem[ix];
      next_st.dq_o = st.rp_d;
      next_st.dq_oe_n = !(st.rp_v && !st.rp_m);
    end
  end

  // every input lands here on the rising edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= RST;
    end else begin
      st <= next_st;
    end
  end

  assign bus.mem_dq_o = st.dq_o;
  assign bus.mem_dq_oe_n = st.dq_oe_n;
  assign open_banks = st.open;
  assign refresh_done = st.refresh_done;
  assign access_error = st.access_error;
  assign powered_down = st.powered_down;
endmodule : sdc_mem

// ===== tb/sdc_link_sva.sv
// Purpose: protocol checker on the controller to device link
// Assumes: controller built with its default burst length of four
// Notes: sees the interface signals only, one clock domain
`timescale 1ns/1ps
`include "sdc_regs.svh"
module sdc_link_sva import sdc_pkg::*; (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [`SDC_ADDR_W-1:0] addr,
  input wire logic ctl_dq_oe_n,
  input wire logic mem_dq_oe_n
);
  typedef struct packed {
    logic [7:0] since_act;
    logic [8:0] since_ref;
  } sdc_chk_type;
  sdc_chk_type st, next_st;
  logic sel, is_act, is_rd, is_wr, is_pre, is_ref, is_lmr, is_nop;
  logic [2:0] code;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // command decode of the pins
  assign sel = cke && !cs_n;
  assign code = {ras_n, cas_n, we_n};
  assign is_act = sel && code == SDC_ACT;
  assign is_rd = sel && code == SDC_RD;
  assign is_wr = sel && code == SDC_WR;
  assign is_pre = sel && code == SDC_PRE;
  assign is_ref = sel && code == SDC_REF;
  assign is_lmr = sel && code == SDC_LMR;
  assign is_nop = !sel || code == SDC_NOP;
  // cycles since the last activate and last refresh, saturating
  always_comb begin
    next_st = st;
    if (is_act) next_st.since_act = 8'h00;
    else if (st.since_act != 8'hFF) next_st.since_act = st.since_act + 8'h01;
    if (is_ref) next_st.since_ref = 9'h000;
    else if (st.since_ref != 9'h1FF) next_st.since_ref = st.since_ref + 9'h001;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) st <= '0;
    else st <= next_st;
  end
  a_no_bus_fight: assert property (ctl_dq_oe_n || mem_dq_oe_n)
    else $error("both ends drive the data bus");
  a_read_burst: assert property (
    is_rd |-> ##2 !mem_dq_oe_n [*4] ##1 mem_dq_oe_n)
    else $error("read burst not four words at latency two");
  a_write_burst: assert property (
    is_wr |-> !ctl_dq_oe_n [*4] ##1 ctl_dq_oe_n)
    else $error("write burst not four words");
  // activate two cycles before the column command leaves one cycle between
  a_rcd_gap: assert property (
    is_rd || is_wr |-> st.since_act >= 8'h01)
    else $error("column command too soon after activate");
  a_ap_no_pre: assert property (
    (is_rd || is_wr) && addr[`SDC_PRE_BIT] |=> !is_pre [*6])
    else $error("precharge issued with auto precharge");
  a_pre_after_wr: assert property (
    is_wr && !addr[`SDC_PRE_BIT] |-> ##4 is_pre)
    else $error("no precharge after plain write burst");
  a_load_mode: assert property (
    $rose(arst_n) |-> ##[0:3] (is_lmr && addr[2:0] == `SDC_BURST_4))
    else $error("no mode load after reset");
  a_refresh_gap: assert property (is_ref |=> is_nop [*6])
    else $error("command inside refresh cycle time");
  a_refresh_due: assert property (st.since_ref < 9'h104)
    else $error("refresh interval overrun");
endmodule : sdc_link_sva

// ===== tb/tb.sv
// Purpose: bench for the sdram controller and device pair
// Assumes: controller burst length four; a second device sits alone
// Notes: the second link is driven by hand with one refused command, then accepted and timed ones
`timescale 1ns/1ps
`include "sdc_regs.svh"
module tb import sdc_pkg::*; ();
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid, req_write, req_autopre, wd_valid;
  logic [`SDC_BA_W-1:0] req_bank;
  logic [`SDC_ROW_W-1:0] req_row;
  logic [`SDC_COL_W-1:0] req_col;
  logic [`SDC_DQ_W-1:0] wd_data, rd_data;
  logic req_ready, wd_ready, rd_valid;
  logic [`SDC_BANKS-1:0] open_banks, open_b2;
  logic refresh_done, access_error, powered_down, ref2, err2, pd2;
  int failures = 0;
  int n_compared = 0;
  int n_ref = 0;
  int n_err = 0;
  // clock inverts every half period
  always #5 clock = ~clock;
  sdc_if link (.clock(clock));
  sdc_if link2 (.clock(clock));
  sdc_ctrl sdc_ctrl_inst (.clock(clock), .arst_n(arst_n), .bus(link.ctrl),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
    .req_autopre(req_autopre), .wd_valid(wd_valid), .wd_ready(wd_ready),
    .wd_data(wd_data), .rd_valid(rd_valid), .rd_data(rd_data));
  sdc_mem sdc_mem_inst (.clock(clock), .arst_n(arst_n), .bus(link.mem),
    .open_banks(open_banks), .refresh_done(refresh_done),
    .access_error(access_error), .powered_down(powered_down));
  sdc_mem sdc_mem_inst2 (.clock(clock), .arst_n(arst_n), .bus(link2.mem),
    .open_banks(open_b2), .refresh_done(ref2), .access_error(err2),
    .powered_down(pd2));
  sdc_link_sva sdc_link_sva_inst (.clock(clock), .arst_n(arst_n),
    .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr),
    .ctl_dq_oe_n(link.ctl_dq_oe_n), .mem_dq_oe_n(link.mem_dq_oe_n));
  // count refreshes taken and commands refused by the main device
  always @(posedge clock) begin
    if (refresh_done === 1'b1) n_ref <= n_ref + 1;
    if (access_error === 1'b1) n_err <= n_err + 1;
  end
  task automatic close_out;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic check(input logic [15:0] g, input logic [15:0] e,
      input string what);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask : check
  task automatic stuck(input string what);
    failures++;
    $display("CHECK FAILED at %0t: timeout on %s", $time, what);
    close_out();
  endtask : stuck
  // hold valid up across words, each word waits for ready
  task automatic push_words(input logic [15:0] base, input int n);
    int i;
    int k;
    wd_valid = 1'b1;
    for (i = 0; i < n; i++) begin
      wd_data = base + 16'(i);
      for (k = 0; k < 100; k++) begin
        @(posedge clock);
        if (wd_ready === 1'b1) break;
      end
      @(negedge clock);
      if (k == 100) stuck("write data");
    end
    wd_valid = 1'b0;
  endtask : push_words
  task automatic request(input logic w, input logic [1:0] b,
      input logic [12:0] r, input logic [8:0] c, input logic ap);
    int k;
    req_valid = 1'b1;
    req_write = w;
    req_bank = b;
    req_row = r;
    req_col = c;
    req_autopre = ap;
    for (k = 0; k < 100; k++) begin
      @(posedge clock);
      if (req_ready === 1'b1) break;
    end
    @(negedge clock);
    req_valid = 1'b0;
    if (k == 100) stuck("request");
    @(negedge clock);
  endtask : request
  // read four words; word j comes from column cr+j within the block
  task automatic read_check(input logic [1:0] b, input logic [12:0] r,
      input logic [8:0] cr, input logic [8:0] cw, input logic ap,
      input logic [15:0] base);
    logic [15:0] got [4];
    int n;
    int k;
    n = 0;
    request(1'b0, b, r, cr, ap);
    for (k = 0; k < 30 && n < 4; k++) begin
      if (rd_valid === 1'b1) begin
        got[n] = rd_data;
        n++;
      end
      @(negedge clock);
    end
    if (n < 4) stuck("read data");
    for (k = 0; k < 4; k++) begin
      check(got[k], base + 16'((int'(cr) + k - int'(cw)) & 3), "read word");
    end
  endtask : read_check
  // one command on the hand driven link
  task automatic cmd2(input sdc_cmd_type c, input logic [1:0] b,
      input logic [12:0] a);
    {link2.ras_n, link2.cas_n, link2.we_n} = c;
    link2.ba = b;
    link2.addr = a;
    @(negedge clock);
  endtask : cmd2
  // main sequence
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_autopre = 1'b0;
    req_bank = '0;
    req_row = '0;
    req_col = '0;
    wd_valid = 1'b0;
    wd_data = '0;
    link2.cke = 1'b1;
    link2.cs_n = 1'b0;
    {link2.ras_n, link2.cas_n, link2.we_n} = SDC_NOP;
    link2.ba = '0;
    link2.addr = '0;
    link2.dqm = '0;
    link2.ctl_dq_o = '0;
    link2.ctl_dq_oe_n = 1'b1;
    repeat (6) @(negedge clock);
    check({15'h0, req_ready}, 16'h0, "ready in reset");
    arst_n = 1'b1;
    // fill the fifo until it refuses
    push_words(16'hA000, 8);
    @(negedge clock);
    check({15'h0, wd_ready}, 16'h0, "fifo full");
    request(1'b1, 2'h1, 13'h0000, 9'h1F6, 1'b0);
    request(1'b1, 2'h2, 13'h1FFF, 9'h000, 1'b1);
    read_check(2'h2, 13'h1FFF, 9'h002, 9'h000, 1'b1, 16'hA004);
    read_check(2'h1, 13'h0000, 9'h1F4, 9'h1F6, 1'b0, 16'hA000);
    check({15'h0, wd_ready}, 16'h1, "fifo drained");
    push_words(16'hC000, 4);
    request(1'b1, 2'h1, 13'h1FFF, 9'h1F4, 1'b0);
    read_check(2'h1, 13'h1FFF, 9'h1F4, 9'h1F4, 1'b1, 16'hC000);
    read_check(2'h1, 13'h0000, 9'h1F4, 9'h1F6, 1'b0, 16'hA000);
    repeat (260) @(negedge clock);
    check({15'h0, n_ref > 0}, 16'h1, "refresh seen");
    check(16'(n_err), 16'h0, "main link refusals");
    check({11'h0, powered_down, open_banks}, 16'h0, "main idle");
    // second link: refused, accepted and timed commands
    cmd2(SDC_RD, 2'h0, 13'h0000);
    check({15'h0, err2}, 16'h1, "read to closed bank");
    cmd2(SDC_ACT, 2'h3, 13'h1FFF);
    check({12'h0, open_b2}, 16'h8, "bank opened");
    cmd2(SDC_NOP, 2'h0, 13'h0000);
    link2.ctl_dq_o = 16'h5A5A;
    link2.ctl_dq_oe_n = 1'b0;
    cmd2(SDC_WR, 2'h3, 13'h0005);
    link2.ctl_dq_oe_n = 1'b1;
    cmd2(SDC_RD, 2'h3, 13'h0005);
    cmd2(SDC_NOP, 2'h0, 13'h0000);
    check(link2.dq, 16'h5A5A, "single read");
    cmd2(SDC_PRE, 2'h3, 13'h0000);
    cmd2(SDC_NOP, 2'h0, 13'h0000);
    cmd2(SDC_NOP, 2'h0, 13'h0000);
    check({12'h0, open_b2}, 16'h0, "bank closed");
    cmd2(SDC_REF, 2'h0, 13'h0000);
    check({15'h0, ref2}, 16'h1, "refresh taken");
    repeat (7) cmd2(SDC_NOP, 2'h0, 13'h0000);
    // full page read cut short by terminate: data stops two edges later
    cmd2(SDC_LMR, 2'h0, 13'h0007);
    cmd2(SDC_ACT, 2'h0, 13'h0000);
    cmd2(SDC_RD, 2'h0, 13'h0000);
    cmd2(SDC_BST, 2'h0, 13'h0000);
    cmd2(SDC_NOP, 2'h0, 13'h0000);
    cmd2(SDC_NOP, 2'h0, 13'h0000);
    check({15'h0, link2.mem_dq_oe_n}, 16'h1, "burst terminated");
    link2.cke = 1'b0;
    @(negedge clock);
    check({15'h0, pd2}, 16'h1, "power down");
    link2.cke = 1'b1;
    @(negedge clock);
    check({15'h0, pd2}, 16'h0, "power up");
    close_out();
  end
endmodule : tb
